// ===== logic/cmd_seq_pkg.sv
// shared constants, types and enumerations of the port command sequencer
// assumes one port clock domain and a 32-slot command list
// Functional notes
// (R01) software sets write bit for PIO writes
// (R02) software clears write bit for PIO reads
// (R03) prefetch: packet bytes, entries, write data, idle
// (R04) packet command: setup frame, then send packet bytes
// (R05) PIO write: setup frame, then one data frame
// (R06) PIO read: setup, entry state, idle, await data
// (R07) PIO read data frame runs receive phase
// (R08) packet write status frame interrupt on bit
// (R09) packet read status frame interrupt on bit
// (R10) last command plus eager sleep requests link sleep
// (R11) only native queued commands, when both support
// (R12) queued tag equals command-list slot index
// (R13) tags limited to smaller queue depth
// (R14) dma setup starts, set-bits frame completes
// (R15) queued commands: no prefetch, matching write bit
// (R16) software sets issue and active bits together
// (R17) dma setup accepted between queued issues
// (R18) set-bits frame clears several slots, may interrupt
// (R19) single block PIO when multi-block not capable
// (R20) PIO data moved by bus mastering
// (R21) status frame without bit raises no interrupt
package cmd_seq_pkg;

  localparam int slot_count = 32;
  localparam int data_width = 32;
  localparam int fifo_depth = 4;
  localparam logic [31:0] slots_reset = 32'h0000_0000;

  // received frame kinds from the link
  typedef enum logic [2:0]
  {
    frame_none,
    frame_pio_setup,
    frame_data,
    frame_status,
    frame_dma_setup,
    frame_set_bits,
    frame_dma_activate
  } frame_kind_e;

  // command slot header fields needed by the sequencer
  typedef struct packed
  {
    logic slot_write_direction_bit;
    logic slot_prefetch_bit;
    logic is_packet;
    logic is_queued;
  } slot_header_s;

  // frame arriving from the drive
  typedef struct packed
  {
    frame_kind_e kind;
    logic irq_bit;
    logic [4:0] tag;
    logic [31:0] done_mask;
  } rx_frame_s;

  // memory fetch requests issued by the sequencer
  typedef enum logic [2:0]
  {
    fetch_none,
    fetch_header,
    fetch_packet,
    fetch_entries,
    fetch_payload
  } fetch_kind_e;

  // lowest set bit of a slot mask, used for issue order
  function automatic logic [4:0] lowest_slot(input logic [31:0] mask);
    logic [4:0] idx;
    idx = 5'h1f;
    for (int i = slot_count - 1; i >= 0; i--)
    begin
      if (mask[i])
      begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : lowest_slot

endpackage : cmd_seq_pkg

// ===== logic/cmd_sequencer.sv
// per-port command sequencer: issues slots, follows frames from the drive
// assumes memory fetches and link framing are done by neighbour blocks
`timescale 1ns/1ps
module cmd_sequencer
  import cmd_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // software side
  input wire logic [31:0] issue_set,
  input wire logic [31:0] active_set,
  input wire logic ncq_supported,
  input wire logic eager_sleep_enable,
  input wire logic multi_block_pio_capable,
  output logic [31:0] command_issue_reg,
  output logic [31:0] active_tag_reg,
  output logic completion_irq,
  output logic legacy_queue_error,
  // memory fetch side
  output fetch_kind_e fetch_req,
  output logic [4:0] fetch_slot,
  input wire logic fetch_done,
  input wire slot_header_s header_in,
  // link transmit side
  output logic cmd_frame_send,
  input wire logic cmd_frame_ok,
  output logic packet_send,
  input wire logic packet_done,
  output logic data_frame_start,
  input wire logic data_frame_end,
  // write data from memory into link
  input wire logic [data_width-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [data_width-1:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  // receive side
  input wire rx_frame_s rx_frame,
  output logic rx_data_to_mem,
  output logic dma_tag_valid,
  output logic [4:0] dma_tag,
  output logic link_sleep_req
);

  typedef enum logic [4:0]
  {
    st_idle,
    st_fetch,
    st_transmit,
    st_pf_packet,
    st_pf_entries,
    early_payload_fetch_state,
    take_control_frame_phase,
    st_pio_entry,
    packet_cmd_entry_state,
    st_pio_update,
    programmed_send_phase,
    programmed_receive_phase,
    status_with_irq_phase,
    st_status_no_irq,
    st_dma_setup,
    st_set_bits,
    eager_link_sleep_check
  } seq_state_e;

  seq_state_e state; // sequencer state
  seq_state_e next_state; // combinational next state
  slot_header_s hdr; // header of the slot in flight
  logic [4:0] cur_slot; // slot in flight
  rx_frame_s frame; // frame held for examination
  logic packet_sent; // packet bytes already sent for this slot

  // fifo outputs
  logic [data_width-1:0] fifo_data;
  logic fifo_valid;

  // decoded frame arrivals, pending slots, completion state and slot mask
  wire logic rx_any = (rx_frame.kind != frame_none);
  wire logic [31:0] pending = command_issue_reg;
  wire logic last_done = (command_issue_reg == slots_reset) &&
                         (active_tag_reg == slots_reset);
  wire logic [31:0] slot_bit = 32'h1 << cur_slot;
  // legacy overlapped queue is refused, only native queuing is served
  wire logic queue_refused = header_in.is_queued && !ncq_supported;

  // write data path through the four word buffer
  word_fifo #(
    .width(data_width),
    .depth(fifo_depth)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(wr_data),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(tx_ready && state == programmed_send_phase)
  );
  // (R20) bus-mastered data
  assign tx_data = fifo_data;
  assign tx_valid = fifo_valid && (state == programmed_send_phase);

  // handshake strobes decoded from state
  assign cmd_frame_send = (state == st_transmit);
  assign packet_send = (state == packet_cmd_entry_state);
  assign data_frame_start = (state == programmed_send_phase);
  assign rx_data_to_mem = (state == programmed_receive_phase);

  // fetch request decode
  always_comb
  begin
    fetch_req = fetch_none;
    unique case (state)
      st_fetch: fetch_req = fetch_header;
      st_pf_packet: fetch_req = fetch_packet;
      st_pf_entries: fetch_req = fetch_entries;
      early_payload_fetch_state: fetch_req = fetch_payload;
      default: fetch_req = fetch_none;
    endcase
  end
  assign fetch_slot = cur_slot;

  // next state logic
  always_comb
  begin
    next_state = state;
    unique case (state)
      st_idle:
        // incoming frames win over new issues
        // (R17) accept frames between issues
        if (rx_any)
          next_state = take_control_frame_phase;
        else if (pending != slots_reset)
          next_state = st_fetch;
      st_fetch:
        if (fetch_done)
          next_state = queue_refused ? st_idle : st_transmit;
      st_transmit:
        // (R03) prefetch order
        if (cmd_frame_ok)
        begin
          if (!hdr.slot_prefetch_bit)
            next_state = st_idle;
          else if (hdr.is_packet)
            next_state = st_pf_packet;
          else
            next_state = st_pf_entries;
        end
      st_pf_packet:
        if (fetch_done)
          next_state = st_pf_entries;
      st_pf_entries:
        if (fetch_done)
          next_state = hdr.slot_write_direction_bit ?
                       early_payload_fetch_state : st_idle;
      early_payload_fetch_state:
        if (fetch_done)
          next_state = st_idle;
      take_control_frame_phase:
        unique case (frame.kind)
          frame_pio_setup: next_state = st_pio_entry;
          // (R07) receive phase
          frame_data: next_state = programmed_receive_phase;
          frame_status: next_state = frame.irq_bit ?
                          status_with_irq_phase : st_status_no_irq;
          // (R14) dma setup starts
          frame_dma_setup: next_state = st_dma_setup;
          frame_set_bits: next_state = st_set_bits;
          default: next_state = st_idle;
        endcase
      st_pio_entry:
        // (R04) packet bytes first
        if (hdr.is_packet && !packet_sent)
          next_state = packet_cmd_entry_state;
        // (R05) write sends data
        else if (hdr.slot_write_direction_bit)
          next_state = programmed_send_phase;
        // (R06) read waits idle
        else
          next_state = st_idle;
      packet_cmd_entry_state:
        if (packet_done)
          next_state = st_pio_update;
      st_pio_update:
        next_state = st_idle;
      programmed_send_phase:
        if (data_frame_end)
          next_state = st_idle;
      programmed_receive_phase:
        if (data_frame_end)
          next_state = st_idle;
      // (R08) (R09) interrupt path
      status_with_irq_phase:
        next_state = eager_link_sleep_check;
      // (R21) quiet completion
      st_status_no_irq:
        next_state = eager_link_sleep_check;
      st_dma_setup:
        next_state = st_idle;
      st_set_bits:
        next_state = eager_link_sleep_check;
      eager_link_sleep_check:
        next_state = st_idle;
      default:
        next_state = st_idle;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= st_idle;
    else
      state <= next_state;
  end

  // slot, header and frame capture
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_slot <= '0;
      hdr <= '0;
      frame <= '0;
      packet_sent <= 1'b0;
    end
    else
    begin
      if (state == st_idle && !rx_any && pending != slots_reset)
        cur_slot <= lowest_slot(pending);
      if (state == st_fetch && fetch_done)
      begin
        hdr <= header_in;
        packet_sent <= 1'b0;
      end
      if (state == st_pio_update)
        packet_sent <= 1'b1;
      if (state == st_idle && rx_any)
        frame <= rx_frame;
    end
  end

  // issue register: set by software, cleared once the command frame is out or the slot is refused;
  // a set in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      command_issue_reg <= slots_reset;
    else if ((state == st_transmit && cmd_frame_ok) ||
             (state == st_fetch && fetch_done && queue_refused))
      command_issue_reg <= (command_issue_reg & ~slot_bit) | issue_set;
    else
      command_issue_reg <= command_issue_reg | issue_set;
  end

  // active tags: set by software, cleared by set-bits frames
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      active_tag_reg <= slots_reset;
    // (R18) clear all indicated
    else if (state == st_set_bits)
      active_tag_reg <= (active_tag_reg & ~frame.done_mask) | active_set;
    else
      active_tag_reg <= active_tag_reg | active_set;
  end

  // event outputs, one cycle each; dma_tag keeps the last setup tag
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      completion_irq <= 1'b0;
      legacy_queue_error <= 1'b0;
      dma_tag_valid <= 1'b0;
      dma_tag <= '0;
      link_sleep_req <= 1'b0;
    end
    else
    begin
      // (R18) set-bits interrupt
      completion_irq <= (state == status_with_irq_phase) ||
                        (state == st_set_bits && frame.irq_bit);
      // (R11) native queuing only
      legacy_queue_error <= (state == st_fetch) && fetch_done &&
                            queue_refused;
      dma_tag_valid <= (state == st_dma_setup);
      if (state == st_dma_setup)
        dma_tag <= frame.tag;
      // (R10) sleep after last
      link_sleep_req <= (state == eager_link_sleep_check) &&
                        eager_sleep_enable && last_done;
    end
  end

  // (R19) capability only informs software; single block is its duty
  wire logic unused_cap = multi_block_pio_capable;

endmodule : cmd_sequencer

// ===== logic/word_fifo.sv
// small first-in first-out buffer for data words
// assumes both sides share clk; ready and valid on each side
`timescale 1ns/1ps
module word_fifo
  import cmd_seq_pkg::*;
#(
  parameter int width = 32,
  parameter int depth = 4
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [width-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [width-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int aw = $clog2(depth);

  logic [width-1:0] mem [depth]; // storage words
  logic [aw:0] wr_ptr; // write pointer with wrap bit
  logic [aw:0] rd_ptr; // read pointer with wrap bit
  logic [width-1:0] head; // registered read data
  logic head_valid; // head register holds a word
  // words held, head register included, so the buffer never takes a fifth
  wire logic [aw:0] held = (wr_ptr - rd_ptr) + {{aw{1'b0}}, head_valid};
  wire logic full = (held == (aw+1)'(depth));
  wire logic empty = (wr_ptr == rd_ptr);
  wire logic push = in_valid && !full;
  // refill the head when it is free or leaves this cycle
  wire logic pop = !empty && (!head_valid || out_ready);

  assign in_ready = !full;
  assign out_data = head;
  assign out_valid = head_valid;

  // storage write, no reset needed for data
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr[aw-1:0]] <= in_data;
    end
  end

  // pointers and head register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      head <= '0;
      head_valid <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
        head <= mem[rd_ptr[aw-1:0]];
        head_valid <= 1'b1;
      end
      else if (out_ready)
      begin
        head_valid <= 1'b0;
      end
    end
  end

endmodule : word_fifo

// ===== verification/drive_model.sv
// behavioural drive and memory model facing the sequencer
// assumes one clock; answers every strobe after lag cycles
`timescale 1ns/1ps
module drive_model
  import cmd_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] lag,
  input wire fetch_kind_e fetch_req,
  input wire logic cmd_frame_send,
  input wire logic packet_send,
  input wire logic data_frame_start,
  input wire logic rx_data_to_mem,
  input wire logic [31:0] tx_data,
  input wire logic tx_valid,
  output logic fetch_done,
  output logic cmd_frame_ok,
  output logic packet_done,
  output logic data_frame_end,
  output logic tx_ready,
  output logic [31:0] words,
  output logic [31:0] last_word
);
  logic [3:0] cnt; // cycles the open strobe has waited
  wire strobe = fetch_req != fetch_none || cmd_frame_send ||
    packet_send || data_frame_start || rx_data_to_mem;
  wire pulsed = fetch_done || cmd_frame_ok || packet_done || data_frame_end;
  // a send frame closes only once the buffer is drained
  wire due = strobe && !pulsed && cnt >= lag &&
    !(data_frame_start && tx_valid);
  // stall every other cycle, as a busy link would
  assign tx_ready = cnt[0];
  // answer each strobe once, then wait for the next
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 4'h0;
      {fetch_done, cmd_frame_ok, packet_done, data_frame_end} <= 4'h0;
      words <= 32'h0;
      last_word <= 32'h0;
    end
    else
    begin
      cnt <= (strobe && !pulsed && !due) ? cnt + 4'h1 : 4'h0;
      fetch_done <= due && fetch_req != fetch_none;
      cmd_frame_ok <= due && cmd_frame_send;
      packet_done <= due && packet_send;
      data_frame_end <= due && (data_frame_start || rx_data_to_mem);
      if (tx_valid && tx_ready)
      begin
        words <= words + 32'h1;
        last_word <= tx_data;
      end
    end
  end
endmodule : drive_model

// ===== verification/seq_monitor.sv
// checker of the sequencer's port timing
// assumes it is bound to cmd_sequencer; one clock, async low reset
`timescale 1ns/1ps
module seq_monitor
  import cmd_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire rx_frame_s rx_frame,
  input wire logic [31:0] issue_set,
  input wire logic [31:0] command_issue_reg,
  input wire logic [31:0] active_tag_reg,
  input wire logic eager_sleep_enable,
  input wire logic completion_irq,
  input wire logic link_sleep_req,
  input wire fetch_kind_e fetch_req,
  input wire logic [4:0] fetch_slot,
  input wire logic fetch_done,
  input wire logic cmd_frame_send,
  input wire logic cmd_frame_ok,
  input wire logic packet_send,
  input wire logic packet_done,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [data_width-1:0] tx_data,
  input wire logic data_frame_start
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // frames that ask for an interrupt, or complete without one
  wire irq_ask = rx_frame.irq_bit &&
    (rx_frame.kind == frame_status || rx_frame.kind == frame_set_bits);
  wire quiet_done = rx_frame.kind == frame_status && !rx_frame.irq_bit;

  irq_follows_a: assert property (irq_ask |-> ##3 completion_irq)
    else $error("interrupt missing");
  irq_cause_a: assert property (completion_irq |-> $past(irq_ask, 3))
    else $error("interrupt without cause");
  quiet_done_a: assert property (quiet_done |-> ##3 !completion_irq)
    else $error("interrupt on quiet status");
  sleep_gate_a: assert property (link_sleep_req |->
    eager_sleep_enable && command_issue_reg == 32'h0 &&
    active_tag_reg == 32'h0) else $error("sleep request too early");
  issue_clear_a: assert property (cmd_frame_send && cmd_frame_ok &&
    !issue_set[fetch_slot] |=> !command_issue_reg[$past(fetch_slot)])
    else $error("issue bit kept");
  fetch_hold_a: assert property (fetch_req != fetch_none &&
    !fetch_done |=> $stable(fetch_req)) else $error("fetch dropped");
  packet_hold_a: assert property (packet_send && !packet_done
    |=> packet_send) else $error("packet strobe dropped");
  send_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("send word not held");
  cover property (completion_irq);
  cover property (link_sleep_req);
  cover property (packet_send && packet_done);
endmodule : seq_monitor

bind cmd_sequencer seq_monitor i_mon (.*);

// ===== verification/testbench.sv
// self-checking bench for the port command sequencer
// assumes drive_model on the far side and seq_monitor bound in
`timescale 1ns/1ps
module testbench
  import cmd_seq_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] issue_set = 32'h0, active_set = 32'h0, wr_data = 32'h0;
  logic ncq_supported = 1'b0, eager_sleep_enable = 1'b0, wr_valid = 1'b0;
  logic multi_block_pio_capable = 1'b0; // one block per PIO command
  logic [3:0] lag = 4'h1;
  slot_header_s header_in = 4'h0;
  rx_frame_s rx_frame = 41'h0;
  logic [31:0] command_issue_reg, active_tag_reg, tx_data, words, last_word;
  logic completion_irq, legacy_queue_error, fetch_done, cmd_frame_send;
  logic cmd_frame_ok, packet_send, packet_done, data_frame_start;
  logic data_frame_end, wr_ready, tx_valid, tx_ready, rx_data_to_mem;
  logic dma_tag_valid, link_sleep_req;
  logic [4:0] fetch_slot, dma_tag;
  fetch_kind_e fetch_req, last_fetch;
  logic [31:0] irq_n = 32'h0, sleep_n = 32'h0, lqe_n = 32'h0;
  logic [31:0] dma_n = 32'h0, pkt_n = 32'h0, rcv_n = 32'h0, flog = 32'h0;
  int num_errors = 0, cmp_count = 0, cycles = 0;
  wire busy = fetch_req != fetch_none || cmd_frame_send || packet_send ||
    data_frame_start || rx_data_to_mem;

  always #2.5 clk = ~clk;
  cmd_sequencer i_dut (.*);
  drive_model i_drive (.*);

  // event counters and fetch order log, plus the hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    last_fetch <= fetch_req;
    if (fetch_req != fetch_none && fetch_req != last_fetch)
      flog <= {flog[27:0], 1'b0, fetch_req};
    irq_n <= irq_n + 32'(completion_irq);
    sleep_n <= sleep_n + 32'(link_sleep_req);
    lqe_n <= lqe_n + 32'(legacy_queue_error);
    dma_n <= dma_n + 32'(dma_tag_valid);
    pkt_n <= pkt_n + 32'(packet_done);
    rcv_n <= rcv_n + 32'(rx_data_to_mem && data_frame_end);
    if (cycles == 20000)
    begin
      num_errors = num_errors + 1;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // wait until no strobe has been up for four cycles
  task automatic settle();
    int q;
    q = 0;
    for (int i = 0; i < 500 && q < 4; i++)
    begin
      @(negedge clk);
      q = busy ? 0 : q + 1;
    end
  endtask : settle

  task automatic issue(input logic [31:0] bits, input logic q);
    @(negedge clk);
    issue_set = bits;
    active_set = q ? bits : 32'h0;
    @(negedge clk);
    issue_set = 32'h0;
    active_set = 32'h0;
  endtask : issue

  task automatic wait_ci(input logic [31:0] v);
    for (int i = 0; i < 500 && command_issue_reg !== v; i++)
      @(negedge clk);
  endtask : wait_ci

  // one-cycle frame arrival; quiet waits for the idle state first
  task automatic frame(input frame_kind_e k, input logic irq,
    input logic [31:0] mask, input logic quiet);
    if (quiet)
      settle();
    rx_frame = '{k, irq, mask[4:0], mask};
    @(negedge clk);
    rx_frame.kind = frame_none;
    settle();
  endtask : frame

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    check(command_issue_reg | active_tag_reg, 32'h0);
    // pio write with prefetch, slow far side; fill buffer until refused
    eager_sleep_enable = 1'b1;
    lag = 4'h5;
    wr_valid = 1'b1;
    for (int i = 0; i < fifo_depth; i++)
    begin
      wr_data = 32'ha0 + 32'(i);
      @(negedge clk);
    end
    wr_valid = 1'b0;
    check(32'(wr_ready), 32'h0);
    header_in = '{1'b1, 1'b1, 1'b0, 1'b0};
    issue(32'h8, 1'b0);
    wait_ci(32'h0);
    settle();
    check(flog & 32'hfff, 32'h134);
    frame(frame_pio_setup, 1'b0, 32'h0, 1'b1);
    check(words, 32'h4);
    check(last_word, 32'ha3);
    check(32'(wr_ready), 32'h1);
    frame(frame_status, 1'b1, 32'h0, 1'b1);
    check(irq_n, 32'h1);
    check(sleep_n, 32'h1);
    // packet pio read with prefetch, prompt far side
    lag = 4'h0;
    header_in = '{1'b0, 1'b1, 1'b1, 1'b0};
    issue(32'h2, 1'b0);
    wait_ci(32'h0);
    settle();
    check(flog & 32'hfff, 32'h123);
    frame(frame_pio_setup, 1'b0, 32'h0, 1'b1);
    check(pkt_n, 32'h1);
    frame(frame_pio_setup, 1'b0, 32'h0, 1'b1);
    check(rcv_n, 32'h0);
    frame(frame_data, 1'b0, 32'h0, 1'b1);
    check(rcv_n, 32'h1);
    frame(frame_status, 1'b0, 32'h0, 1'b1);
    check(irq_n, 32'h1);
    check(sleep_n, 32'h2);
    // queued commands in slots 0, 2, 5 and 8
    ncq_supported = 1'b1;
    lag = 4'h2;
    header_in = '{1'b0, 1'b0, 1'b0, 1'b1};
    // slots 0 to 8 stay under both queue depths
    issue(32'h125, 1'b1);
    check(active_tag_reg, 32'h125);
    wait_ci(32'h100);
    frame(frame_dma_setup, 1'b0, 32'h2, 1'b0);
    wait_ci(32'h0);
    settle();
    check(dma_n, 32'h1);
    check(32'(dma_tag), 32'h2);
    frame(frame_set_bits, 1'b1, 32'h24, 1'b1);
    check(active_tag_reg, 32'h101);
    check(irq_n, 32'h2);
    check(sleep_n, 32'h2);
    frame(frame_set_bits, 1'b1, 32'h101, 1'b1);
    check(active_tag_reg, 32'h0);
    check(sleep_n, 32'h3);
    // queued slot without native queuing is dropped
    ncq_supported = 1'b0;
    issue(32'h10, 1'b0);
    wait_ci(32'h0);
    settle();
    check(lqe_n, 32'h1);
    wrap_up();
  end
endmodule : testbench
